// [design/lsc_pkg.sv]
// Shared constants for the LCD module system command handler.
// Assumes a 200 MHz core clock and packet bytes already de-framed.
package lsc_pkg;

  // Command codes, low six bits of the type byte
  localparam logic [5:0] CMD_PING      = 6'h00;
  localparam logic [5:0] CMD_INFO      = 6'h01;
  localparam logic [5:0] CMD_NV_WRITE  = 6'h02;
  localparam logic [5:0] CMD_NV_READ   = 6'h03;
  localparam logic [5:0] CMD_BOOT_SAVE = 6'h04;
  localparam logic [5:0] CMD_RESTART   = 6'h05;
  localparam logic [5:0] CMD_CLEAR     = 6'h06;
  localparam logic [5:0] CMD_GLYPH     = 6'h09;

  // Type byte upper bits
  localparam logic [1:0] TYPE_CMD = 2'h0;
  localparam logic [1:0] TYPE_RSP = 2'h1;
  localparam logic [1:0] TYPE_ERR = 2'h2;

  // Lengths
  localparam int         MAX_PAYLOAD = 124;
  localparam logic [7:0] MAX_LEN     = 8'h7c;
  localparam logic [7:0] VER_LEN     = 8'h10;
  localparam logic [7:0] SER_LEN     = 8'h11;
  localparam logic [7:0] KEY_LEN     = 8'h03;
  localparam logic [7:0] GLYPH_RLEN  = 8'h09;
  localparam logic [7:0] GLYPH_WLEN  = 8'h09;
  localparam int         GLYPH_COUNT = 8;
  localparam int         GLYPH_ROWS  = 8;

  // Info selectors
  localparam logic [7:0] SEL_VERSION = 8'h00;
  localparam logic [7:0] SEL_SERIAL  = 8'h01;

  // Restart keys, first byte most significant
  localparam logic [23:0] KEY_RELOAD       = 24'h081263;
  localparam logic [23:0] KEY_HOST_RESTART = 24'h0c1c61;
  localparam logic [23:0] KEY_HOST_OFF     = 24'h030b5f;
  localparam logic [23:0] KEY_SELF         = 24'h081930;
  localparam logic [23:0] KEY_FACTORY      = 24'h0a0862;

  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int T_NV_WRITE_MS  = 400;
  localparam int T_RELOAD_MS    = 100;
  localparam int T_RESTART_MS   = 3000;
  localparam int CYC_NV_WRITE   = T_NV_WRITE_MS * CLK_MHZ * 1000;
  localparam int CYC_RELOAD     = T_RELOAD_MS * CLK_MHZ * 1000;
  localparam int CYC_RESTART    = T_RESTART_MS * CLK_MHZ * 1000;

  typedef enum logic [2:0] {S_RX, S_EXEC, S_WRITE, S_COMMIT, S_WAIT, S_TX, S_QUIET}
    lsc_state_t;
  typedef enum logic [2:0] {K_NONE, K_ECHO, K_VER, K_SER, K_NV, K_GLYPH} lsc_kind_t;
  typedef enum logic [2:0] {A_NONE, A_RELOAD, A_HOST_RESTART, A_HOST_OFF, A_SELF,
                            A_FACTORY} lsc_act_t;

endpackage

// [design/lsc_mem_if.sv]
// Byte memory port between the command handler and its storage blocks.
// Reads are combinational; commit starts a timed program cycle.
`timescale 1ns/100ps
interface lsc_mem_if #(parameter int AW = 7);
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          we;
  logic          commit;
  logic [7:0]    rdata;
  logic          busy;

  modport host (output addr, wdata, we, commit, input rdata, busy);
  modport mem  (input addr, wdata, we, commit, output rdata, busy);
endinterface

// [design/lsc_user_nv.sv]
// User nonvolatile byte area with a program-time busy window.
// Assumes the array is kept over module restarts (only arst_n is power).
`timescale 1ns/100ps
module lsc_user_nv
  import lsc_pkg::*;
#(
  parameter int DEPTH    = MAX_PAYLOAD,
  parameter int BUSY_CYC = CYC_NV_WRITE
)(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Storage port
  lsc_mem_if.mem    bus
);
  logic [7:0]  mem [DEPTH];
  logic [31:0] cnt;

  // Only writes touch the array; nothing clears it
  always_ff @(posedge core_clk)
  begin
    if (bus.we)
      mem[bus.addr] <= bus.wdata;
  end

  assign bus.rdata = mem[bus.addr];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 32'h0;
    else if (bus.commit)
      cnt <= 32'(BUSY_CYC);
    else if (cnt != 32'h0)
      cnt <= cnt - 32'h1;
  end

  assign bus.busy = (cnt != 32'h0);

  chk_nv_stable_data: assert property (@(posedge core_clk) disable iff (!arst_n)
    !bus.we ##1 $stable(bus.addr) |-> $stable(bus.rdata))
    else $error("User area changed without a write");

  chk_nv_busy_start: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus.commit |=> bus.busy && cnt == 32'(BUSY_CYC))
    else $error("Program window did not start");
endmodule // lsc_user_nv

// [design/lsc_glyph_mem.sv]
// Glyph pattern memory: eight glyphs of eight rows each.
// Assumes the caller keeps the index in range.
`timescale 1ns/100ps
module lsc_glyph_mem
  import lsc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Pattern port, address is {glyph, row}
  lsc_mem_if.mem    bus
);
  logic [7:0] glyph_pattern_memory [GLYPH_COUNT*GLYPH_ROWS];

  always_ff @(posedge core_clk)
  begin
    if (bus.we)
      glyph_pattern_memory[bus.addr] <= bus.wdata;
  end

  assign bus.rdata = glyph_pattern_memory[bus.addr];
  // Pattern writes are immediate, so never busy
  assign bus.busy  = 1'b0;

  chk_glyph_readback: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus.we |=> glyph_pattern_memory[$past(bus.addr)] == $past(bus.wdata))
    else $error("Glyph row not stored");
endmodule // lsc_glyph_mem

// [design/lsc_cmd_handler.sv]
// System command interpreter: takes one de-framed packet, answers it.
// Assumes type, length, payload arrive as a byte stream ending in rx_last.
// Operation
// - Every answer echoes command low six bits
// - Ping echoes length and payload, type 0x40
// - Info selector absent/0 version, 1 serial
// - Version reply is 16 bytes, type 0x41
// - Serial reply is 17 bytes, same type
// - 124-byte user area untouched by others
// - User write replies after program time
// - User read returns exactly requested count
// - Save state as boot, reply when done
// - Watchdog never part of boot state
// - Reload key: ack, then 100 ms deaf
// - Host-restart key: ack, ATX, fans, self
// - Host-off key: ATX off, fans, self restart
// - Self key: ack, restart, up to 3 s
// - Factory key: defaults, restart, keep user area
// - Restart acks are type 0x45, empty
// - Clear display, buffers, cursor home, video stop
// - Glyph read returns index plus eight rows
// - Glyph write stores eight rows, empty reply
// - No user glyphs under custom font
`timescale 1ns/100ps
module lsc_cmd_handler
  import lsc_pkg::*;
#(
  parameter int           STATE_W      = 64,
  parameter int           NV_WRITE_CYC = CYC_NV_WRITE,
  parameter int           RELOAD_CYC   = CYC_RELOAD,
  parameter int           RESTART_CYC  = CYC_RESTART,
  // Arbitrary identity values
  parameter logic [127:0] VERSION_ID   = "LCDMOD:h1.0,f1.0",
  parameter logic [135:0] SERIAL_ID    = "SN000000000000001",
  parameter logic [STATE_W-1:0] BOOT_DEFAULT = '0
)(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // Command byte stream
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_last,
  output logic                    rx_ready,
  // Answer byte stream
  input  wire logic               tx_ready,
  output logic                    tx_valid,
  output logic [7:0]              tx_byte,
  output logic                    tx_last,
  // Device state, watchdog excluded
  input  wire logic [STATE_W-1:0] cur_state,
  input  wire logic               custom_font_active,
  output logic [STATE_W-1:0]      boot_state,
  // Action strobes, one cycle each; glyph_render_en is a level
  output logic                    boot_load,
  output logic                    atx_host_restart,
  output logic                    atx_host_off,
  output logic                    fan_restart,
  output logic                    self_restart,
  output logic                    watchdog_off,
  output logic                    display_clear,
  output logic                    video_stop,
  output logic                    glyph_render_en
);
  lsc_mem_if #(.AW(7)) nv ();
  lsc_mem_if #(.AW(6)) gl ();

  lsc_user_nv #(.DEPTH(MAX_PAYLOAD), .BUSY_CYC(NV_WRITE_CYC)) u_nv (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .bus      (nv.mem)
  );

  lsc_glyph_mem u_glyph (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .bus      (gl.mem)
  );

  lsc_state_t  state;
  lsc_kind_t   kind;
  lsc_act_t    act;
  logic [7:0]  rx_buf [MAX_PAYLOAD];
  logic [7:0]  rx_type;
  logic [7:0]  rx_len;
  logic [7:0]  rx_idx;
  logic [7:0]  rx_cnt;
  logic [7:0]  rsp_type;
  logic [7:0]  rsp_len;
  logic [7:0]  tx_idx;
  logic [7:0]  tx_pos;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_end;
  logic        wr_nv;
  logic [2:0]  gidx;
  logic [31:0] quiet_cnt;
  logic [7:0]  pay_idx;
  logic [7:0]  next_byte;
  logic [5:0]  code;
  logic [23:0] key;
  logic        len_ok;

  assign code    = rx_type[5:0];
  assign key     = {rx_buf[0], rx_buf[1], rx_buf[2]};
  assign len_ok  = (rx_cnt == rx_len) && (rx_type[7:6] == TYPE_CMD);
  assign pay_idx = tx_idx - 8'h2;

  // Storage ports: writes in S_WRITE, otherwise addressed by the answer
  assign nv.addr   = (state == S_WRITE) ? wr_idx[6:0] : pay_idx[6:0];
  assign nv.wdata  = rx_buf[wr_idx[6:0]];
  assign nv.we     = (state == S_WRITE) && wr_nv;
  assign nv.commit = (state == S_COMMIT);
  assign gl.addr   = (state == S_WRITE) ? {gidx, wr_idx[2:0]} : {gidx, pay_idx[2:0] - 3'h1};
  assign gl.wdata  = rx_buf[wr_idx[6:0] + 7'h1];
  assign gl.we     = (state == S_WRITE) && !wr_nv;
  assign gl.commit = 1'b0;

  // Byte that the answer stream carries at position tx_idx
  always_comb
  begin
    next_byte = 8'h0;
    if (tx_idx == 8'h0)
      next_byte = rsp_type;
    else if (tx_idx == 8'h1)
      next_byte = rsp_len;
    else
      case (kind)
        K_ECHO:  next_byte = rx_buf[pay_idx[6:0]];
        K_VER:   next_byte = VERSION_ID[8*(15 - int'(pay_idx[3:0])) +: 8];
        K_SER:   next_byte = SERIAL_ID[8*(16 - int'(pay_idx[4:0])) +: 8];
        K_NV:    next_byte = nv.rdata;
        K_GLYPH: next_byte = (pay_idx == 8'h0) ? {5'h0, gidx} : gl.rdata;
        default: next_byte = 8'h0;
      endcase
  end

  // Packet intake; payload beyond the area is counted, not kept
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_idx  <= 8'h0;
      rx_cnt  <= 8'h0;
      rx_type <= 8'h0;
      rx_len  <= 8'h0;
    end
    else if (state == S_RX && rx_valid && rx_ready)
    begin
      rx_idx <= rx_last ? 8'h0 : ((rx_idx == 8'hff) ? rx_idx : rx_idx + 8'h1);
      if (rx_idx == 8'h0)
      begin
        rx_type <= rx_byte;
        rx_cnt  <= 8'h0;
      end
      else if (rx_idx == 8'h1)
        rx_len <= rx_byte;
      else if (rx_cnt != 8'hff)
        rx_cnt <= rx_cnt + 8'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (state == S_RX && rx_valid && rx_ready && rx_idx >= 8'h2 && rx_cnt < MAX_LEN)
      rx_buf[rx_cnt[6:0]] <= rx_byte;
  end

  // Decode, execute and sequence
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= S_RX;
      rx_ready  <= 1'b1;
      kind      <= K_NONE;
      act       <= A_NONE;
      rsp_type  <= 8'h0;
      rsp_len   <= 8'h0;
      wr_idx    <= 8'h0;
      wr_end    <= 8'h0;
      wr_nv     <= 1'b0;
      gidx      <= 3'h0;
      quiet_cnt <= 32'h0;
    end
    else
      case (state)
        S_RX:
          if (rx_valid && rx_ready && rx_last)
          begin
            state    <= S_EXEC;
            rx_ready <= 1'b0;
          end
        S_EXEC:
        begin
          kind     <= K_NONE;
          act      <= A_NONE;
          rsp_len  <= 8'h0;
          rsp_type <= {TYPE_ERR, code};
          wr_idx   <= 8'h0;
          state    <= S_TX;
          if (len_ok)
            case (code)
              CMD_PING:
                if (rx_len <= MAX_LEN)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  rsp_len  <= rx_len;
                  kind     <= K_ECHO;
                end
              CMD_INFO:
                if (rx_len == 8'h0 || (rx_len == 8'h1 && rx_buf[0] == SEL_VERSION))
                begin
                  rsp_type <= {TYPE_RSP, code};
                  rsp_len  <= VER_LEN;
                  kind     <= K_VER;
                end
                else if (rx_len == 8'h1 && rx_buf[0] == SEL_SERIAL)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  rsp_len  <= SER_LEN;
                  kind     <= K_SER;
                end
              CMD_NV_WRITE:
                if (rx_len != 8'h0 && rx_len <= MAX_LEN)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  wr_end   <= rx_len - 8'h1;
                  wr_nv    <= 1'b1;
                  state    <= S_WRITE;
                end
              CMD_NV_READ:
                if (rx_len == 8'h1 && rx_buf[0] != 8'h0 && rx_buf[0] <= MAX_LEN)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  rsp_len  <= rx_buf[0];
                  kind     <= K_NV;
                end
              CMD_BOOT_SAVE:
                if (rx_len == 8'h0)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  state    <= S_COMMIT;
                end
              CMD_RESTART:
                if (rx_len == KEY_LEN)
                begin
                  rsp_type <= {TYPE_RSP, code};
                  case (key)
                    KEY_RELOAD:       act <= A_RELOAD;
                    KEY_HOST_RESTART: act <= A_HOST_RESTART;
                    KEY_HOST_OFF:     act <= A_HOST_OFF;
                    KEY_SELF:         act <= A_SELF;
                    KEY_FACTORY:      act <= A_FACTORY;
                    default:          rsp_type <= {TYPE_ERR, code};
                  endcase
                end
              CMD_CLEAR:
                if (rx_len == 8'h0)
                  rsp_type <= {TYPE_RSP, code};
              CMD_GLYPH:
                if (rx_len == 8'h1 && rx_buf[0] < 8'(GLYPH_COUNT))
                begin
                  rsp_type <= {TYPE_RSP, code};
                  rsp_len  <= GLYPH_RLEN;
                  gidx     <= rx_buf[0][2:0];
                  kind     <= K_GLYPH;
                end
                else if (rx_len == GLYPH_WLEN && rx_buf[0] < 8'(GLYPH_COUNT))
                begin
                  rsp_type <= {TYPE_RSP, code};
                  gidx     <= rx_buf[0][2:0];
                  wr_end   <= 8'(GLYPH_ROWS - 1);
                  wr_nv    <= 1'b0;
                  state    <= S_WRITE;
                end
              default: ;
            endcase
        end
        S_WRITE:
        begin
          wr_idx <= wr_idx + 8'h1;
          if (wr_idx == wr_end)
            state <= wr_nv ? S_COMMIT : S_TX;
        end
        S_COMMIT:
          state <= S_WAIT;
        S_WAIT:
          if (!nv.busy)
            state <= S_TX;
        S_TX:
          if (tx_valid && tx_ready && tx_last)
          begin
            rx_ready <= 1'b1;
            if (act == A_NONE)
              state <= S_RX;
            else
            begin
              // Input is swallowed until the restart settles
              state     <= S_QUIET;
              quiet_cnt <= (act == A_RELOAD) ? 32'(RELOAD_CYC) : 32'(RESTART_CYC);
            end
          end
        S_QUIET:
          if (quiet_cnt <= 32'h1)
          begin
            state <= S_RX;
            act   <= A_NONE;
          end
          else
            quiet_cnt <= quiet_cnt - 32'h1;
        default:
          state <= S_RX;
      endcase
  end

  // Answer stream, held while tx_ready is low
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h0;
      tx_last  <= 1'b0;
      tx_idx   <= 8'h0;
      tx_pos   <= 8'h0;
    end
    else if (state != S_TX)
      tx_idx <= 8'h0;
    else if (tx_valid && tx_ready && tx_last)
    begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
    else if (!tx_valid || tx_ready)
    begin
      tx_valid <= 1'b1;
      tx_byte  <= next_byte;
      tx_last  <= (tx_idx == rsp_len + 8'h1);
      tx_pos   <= tx_idx;
      tx_idx   <= tx_idx + 8'h1;
    end
  end

  // Side effects fire after the acknowledgement has left
  logic ack_done;
  assign ack_done = (state == S_TX) && tx_valid && tx_ready && tx_last
                    && rsp_type[7:6] == TYPE_RSP;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_load        <= 1'b0;
      atx_host_restart <= 1'b0;
      atx_host_off     <= 1'b0;
      fan_restart      <= 1'b0;
      self_restart     <= 1'b0;
      watchdog_off     <= 1'b0;
      display_clear    <= 1'b0;
      video_stop       <= 1'b0;
    end
    else
    begin
      boot_load        <= ack_done && act == A_RELOAD;
      atx_host_restart <= ack_done && act == A_HOST_RESTART;
      atx_host_off     <= ack_done && act == A_HOST_OFF;
      fan_restart      <= ack_done && act inside {A_HOST_RESTART, A_HOST_OFF, A_SELF,
                                                  A_FACTORY};
      self_restart     <= ack_done && act inside {A_HOST_RESTART, A_HOST_OFF, A_SELF,
                                                  A_FACTORY};
      watchdog_off     <= ack_done && act != A_NONE;
      display_clear    <= ack_done && code == CMD_CLEAR;
      video_stop       <= ack_done && code == CMD_CLEAR;
    end
  end

  // Boot image never carries watchdog settings
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      boot_state <= BOOT_DEFAULT;
    else if (state == S_COMMIT && code == CMD_BOOT_SAVE)
      boot_state <= cur_state;
    else if (ack_done && act == A_FACTORY)
      boot_state <= BOOT_DEFAULT;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      glyph_render_en <= 1'b0;
    else
      glyph_render_en <= !custom_font_active;
  end

  chk_type_echo: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h0 |-> tx_byte[5:0] == rx_type[5:0])
    else $error("Answer type does not echo command");
  chk_ping_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h1 && kind == K_ECHO |-> tx_byte == rx_len)
    else $error("Ping length not echoed");
  chk_version_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && kind == K_VER && tx_pos <= 8'h1
      |-> tx_byte == ((tx_pos == 8'h0) ? 8'h41 : VER_LEN))
    else $error("Version reply malformed");
  chk_serial_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h1 && kind == K_SER |-> tx_byte == 8'h11)
    else $error("Serial reply length wrong");
  chk_write_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && rsp_type == 8'h42 |-> !nv.busy)
    else $error("Write acknowledged before completion");
  chk_read_count: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h1 && kind == K_NV |-> tx_byte == rx_buf[0])
    else $error("Read length differs from request");
  chk_quiet_deaf: assert property (@(posedge core_clk) disable iff (!arst_n)
    state == S_QUIET |-> rx_ready && !tx_valid)
    else $error("Traffic during restart window");
  chk_act_after_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(atx_host_restart) |-> $past(tx_valid && tx_ready && tx_last))
    else $error("Host restart before acknowledgement");
  chk_restart_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h1 && rsp_type == 8'h45 |-> tx_byte == 8'h00 && tx_last)
    else $error("Restart ack not empty");
  chk_glyph_len: assert property (@(posedge core_clk) disable iff (!arst_n)
    tx_valid && tx_pos == 8'h1 && kind == K_GLYPH |-> tx_byte == 8'h09)
    else $error("Glyph read length wrong");
  chk_font_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    custom_font_active |=> !glyph_render_en)
    else $error("Glyphs enabled under custom font");
endmodule // lsc_cmd_handler

// [verif/lsc_host_model.sv]
// Host-side sink for answer packets; can stall.
// Assumes one answer in flight at a time.
`timescale 1ns/100ps
module lsc_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Answer stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Stall every other cycle
  input  wire logic       slow
);
  logic [7:0] rsp[$];
  int         n_ans;
  // Answer bytes are queued in arrival order; tx_last counts packets
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_ready <= 1'b0;
      n_ans = 0;
    end
    else
    begin
      if (tx_valid && tx_ready)
      begin
        rsp.push_back(tx_byte);
        n_ans += tx_last;
      end
      tx_ready <= slow ? !tx_ready : 1'b1;
    end
  end
endmodule // lsc_host_model

// [verif/test_lsc_cmd_handler.sv]
// Self-checking bench for the system command handler.
// Assumes shortened program and quiet times.
`timescale 1ns/100ps
module test_lsc_cmd_handler
  import lsc_pkg::*;
;
  logic        core_clk, arst_n, rx_valid, rx_last, rx_ready, tx_ready, tx_valid, tx_last;
  logic        slow, custom_font_active, boot_load, atx_host_restart, atx_host_off;
  logic        fan_restart, self_restart, watchdog_off, display_clear, video_stop;
  logic        glyph_render_en;
  logic [7:0]  rx_byte, tx_byte, seen;
  logic [63:0] cur_state, boot_state;
  int          fail_count, num_checks, cyc;

  lsc_cmd_handler #(.NV_WRITE_CYC(20), .RELOAD_CYC(10), .RESTART_CYC(30)) dut (
    .core_clk, .arst_n, .rx_valid, .rx_byte, .rx_last, .rx_ready, .tx_ready, .tx_valid,
    .tx_byte, .tx_last, .cur_state, .custom_font_active, .boot_state, .boot_load,
    .atx_host_restart, .atx_host_off, .fan_restart, .self_restart, .watchdog_off,
    .display_clear, .video_stop, .glyph_render_en);
  lsc_host_model host (.core_clk, .arst_n, .tx_valid, .tx_byte, .tx_last, .tx_ready, .slow);

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    seen <= seen | {boot_load, atx_host_restart, atx_host_off, fan_restart, self_restart,
                    watchdog_off, display_clear, video_stop};

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Whole packet in, then wait for the full answer before the next one
  task automatic xfer(input logic [7:0] q[$], input bit want);
    int n;
    n = host.n_ans;
    #1;
    seen = '0;
    host.rsp.delete();
    @(posedge core_clk);
    foreach (q[i])
    begin
      rx_valid <= 1'b1;
      rx_byte  <= q[i];
      rx_last  <= (i == q.size() - 1);
      do @(posedge core_clk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    repeat (want ? 400 : 40)
      if (host.n_ans == n) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk("answers", n + want, host.n_ans);
  endtask

  task automatic hdr(logic [7:0] t, logic [7:0] l);
    chk("type", t, host.rsp[0]);
    chk("length", l, host.rsp[1]);
    chk("size", l + 2, host.rsp.size());
  endtask

  task automatic t_ping;
    slow <= 1'b1;
    xfer({8'h00, 8'h03, 8'ha1, 8'hb2, 8'hc3}, 1);
    hdr(8'h40, 8'h03);
    chk("echo", 24'ha1b2c3, {host.rsp[2], host.rsp[3], host.rsp[4]});
    slow <= 1'b0;
    $display("test ping done");
  endtask

  task automatic t_info;
    xfer({8'h01, 8'h00}, 1);
    hdr(8'h41, VER_LEN);
    xfer({8'h01, 8'h01, 8'h00}, 1);
    hdr(8'h41, VER_LEN);
    xfer({8'h01, 8'h01, 8'h01}, 1);
    hdr(8'h41, SER_LEN);
    $display("test info done");
  endtask

  task automatic t_glyph;
    logic [7:0] g[$];
    g = {8'h09, 8'h09, 8'h03};
    for (int i = 0; i < 8; i++)
      g.push_back(8'h81 ^ 8'(i));
    xfer(g, 1);
    hdr(8'h49, 8'h00);
    xfer({8'h09, 8'h01, 8'h03}, 1);
    hdr(8'h49, GLYPH_RLEN);
    for (int i = 2; i < 11; i++)
      chk("glyph byte", g[i], host.rsp[i]);
    xfer({8'h09, 8'h01, 8'h08}, 1);
    hdr(8'h89, 8'h00);
    custom_font_active <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("render", 1'b0, glyph_render_en);
    custom_font_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("render", 1'b1, glyph_render_en);
    $display("test glyph done");
  endtask

  task automatic t_nv;
    int c0;
    c0 = cyc;
    xfer({8'h02, 8'h02, 8'h5a, 8'ha5}, 1);
    hdr(8'h42, 8'h00);
    chk("write wait", 1'b1, cyc - c0 > 20);
    xfer({8'h03, 8'h01, 8'h02}, 1);
    hdr(8'h43, 8'h02);
    chk("user data", 16'h5aa5, {host.rsp[2], host.rsp[3]});
    cur_state <= 64'h0123456789abcdef;
    xfer({8'h04, 8'h00}, 1);
    hdr(8'h44, 8'h00);
    chk("boot image", 64'h0123456789abcdef, boot_state);
    xfer({8'h06, 8'h00}, 1);
    hdr(8'h46, 8'h00);
    chk("clear strobes", 8'h03, seen & 8'h03);
    $display("test nv done");
  endtask

  task automatic t_restart;
    logic [23:0] key [5] = '{KEY_RELOAD, KEY_HOST_RESTART, KEY_HOST_OFF, KEY_SELF, KEY_FACTORY};
    logic [7:0]  exp [5] = '{8'h84, 8'h5c, 8'h3c, 8'h1c, 8'h1c};
    for (int k = 0; k < 5; k++)
    begin
      xfer({8'h05, 8'h03, key[k][23:16], key[k][15:8], key[k][7:0]}, 1);
      hdr(8'h45, 8'h00);
      chk("strobes", exp[k], seen);
      if (k == 0)
        xfer({8'h00, 8'h00}, 0);
      repeat (40) @(posedge core_clk);
    end
    chk("boot default", 64'h0, boot_state);
    xfer({8'h05, 8'h03, 8'h01, 8'h02, 8'h03}, 1);
    hdr(8'h85, 8'h00);
    xfer({8'h07, 8'h00}, 1);
    hdr(8'h87, 8'h00);
    xfer({8'h06, 8'h01}, 1);
    hdr(8'h86, 8'h00);
    xfer({8'h03, 8'h01, 8'h00}, 1);
    hdr(8'h83, 8'h00);
    xfer({8'h03, 8'h01, 8'h02}, 1);
    chk("user data kept", 16'h5aa5, {host.rsp[2], host.rsp[3]});
    $display("test restart done");
  endtask

  initial
  begin
    arst_n = 1'b0;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_byte = 8'h00;
    slow = 1'b0;
    custom_font_active = 1'b0;
    cur_state = 64'h0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_ping();
    t_info();
    t_glyph();
    t_nv();
    t_restart();
    results();
  end
endmodule // test_lsc_cmd_handler
